/* File: logic/tmr_pair.sv */
// cascadable pair of 8-bit timer channels with cpu contention handling
`timescale 1ns/100ps
`include "tmr_defines.svh"
module tmr_pair import tmr_pkg::*; (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [2:0] upper_clock_sel,
	input  wire logic [2:0] lower_clock_sel,
	input  wire logic [1:0] upper_clear_sel,
	input  wire logic [1:0] lower_clear_sel,
	input  wire logic [1:0] upper_out_sel_a,
	input  wire logic [1:0] upper_out_sel_b,
	input  wire logic [1:0] lower_out_sel_a,
	input  wire logic [1:0] lower_out_sel_b,
	input  wire logic       capture_enable,
	input  wire logic [1:0] capture_edge_sel,
	input  wire logic       conv_trigger_enable,
	input  wire logic       lower_match_a_ie,
	input  wire logic       lower_match_b_ie,
	input  wire logic       upper_ovf_ie,
	input  wire logic       lower_ovf_ie,
	input  wire logic [5:0] flag_clear,
	input  wire logic       ext_clock_pin,
	input  wire logic       capture_pin,
	input  wire logic       ext_conv_trigger_pin,
	input  wire logic [2:0] cpu_sel,
	input  wire logic       cpu_wr_t2,
	input  wire logic       cpu_wr_t3,
	input  wire logic       cpu_rd_t3,
	input  wire logic [7:0] cpu_wdata,
	output logic      [7:0] cpu_rdata,
	output logic      [5:0] flags,
	output logic            upper_timer_out,
	output logic            lower_timer_out,
	output logic            conv_start_req,
	output logic            conv_ext_trigger,
	output logic            lower_match_irq,
	output logic            shared_ovf_irq
);
	tmr_core_s   s;
	tmr_core_s   next_s;
	logic        cascade16;
	logic        count_match;
	logic        eq_ua;
	logic        eq_ub;
	logic        eq_la;
	logic        eq_lb;
	logic        m_ua;
	logic        m_ub;
	logic        m_la;
	logic        m_lb;
	logic        cap;
	logic        clr_hi;
	logic        clr_lo;
	logic        tick_hi;
	logic        tick_lo;
	logic        inc_hi;
	logic        inc_lo;
	logic        ovf_hi;
	logic        ovf_lo;
	logic        wr_cnt_hi;
	logic        wr_cnt_lo;
	logic        wr_cb_hi;
	logic        wr_cb_lo;
	logic [16:0] sum16;
	logic [15:0] base16;
	logic [5:0]  set_flags;
	logic [2:0]  taps;

	// ************************************************************
	// clock sources
	// ************************************************************

	// prescaler taps feed both edge detectors
	assign taps = {s.presc[`TMR_TAP3_BIT], s.presc[`TMR_TAP2_BIT], s.presc[`TMR_TAP1_BIT]};

	tmr_tick u_tick_hi (
		.clock         (clock),
		.rst           (rst),
		.clock_sel     (upper_clock_sel),
		.taps          (taps),
		.ext_level     (s.clk_s2),
		.cascade_pulse (1'b0),
		.tick          (tick_hi)
	);

	// in compare match count mode the lower byte counts upper match a
	tmr_tick u_tick_lo (
		.clock         (clock),
		.rst           (rst),
		.clock_sel     (lower_clock_sel),
		.taps          (taps),
		.ext_level     (s.clk_s2),
		.cascade_pulse (m_ua & count_match),
		.tick          (tick_lo)
	);

	// ************************************************************
	// compare, capture and clear events
	// ************************************************************

	// 16-bit count puts the upper channel in the high byte
	always_comb begin
		cascade16   = (upper_clock_sel == `TMR_CS_CASCADE);
		count_match = (lower_clock_sel == `TMR_CS_CASCADE) && !cascade16;
		eq_la = (s.cnt_lo == s.ca_lo);
		eq_lb = (s.cnt_lo == s.cb_lo) && !capture_enable;
		eq_ua = (s.cnt_hi == s.ca_hi) && (!cascade16 || eq_la);
		eq_ub = (s.cnt_hi == s.cb_hi) && !capture_enable
			&& (!cascade16 || (s.cnt_lo == s.cb_lo));
	end

	// a match fires on arrival; a T3 write to its constant kills it
	always_comb begin
		m_ua = eq_ua && !s.eq_prev[0]
			&& !(cpu_wr_t3 && (cpu_sel == `TMR_SEL_CA_HI
			|| (cascade16 && cpu_sel == `TMR_SEL_CA_LO)));
		m_ub = eq_ub && !s.eq_prev[1]
			&& !(cpu_wr_t3 && (cpu_sel == `TMR_SEL_CB_HI
			|| (cascade16 && cpu_sel == `TMR_SEL_CB_LO)));
		m_la = eq_la && !s.eq_prev[2] && !(cpu_wr_t3 && cpu_sel == `TMR_SEL_CA_LO);
		m_lb = eq_lb && !s.eq_prev[3] && !(cpu_wr_t3 && cpu_sel == `TMR_SEL_CB_LO);
	end

	// capture edge on the synchronised pin
	always_comb begin
		cap = 1'b0;
		if (capture_edge_sel == `TMR_EDGE_RISE) begin
			cap = s.cap_s2 && !s.cap_prev;
		end else if (capture_edge_sel == `TMR_EDGE_FALL) begin
			cap = !s.cap_s2 && s.cap_prev;
		end else if (capture_edge_sel != 2'h0) begin
			cap = s.cap_s2 != s.cap_prev;
		end
		cap = cap && capture_enable;
	end

	// clear sources; in 16-bit mode the lower select is ignored
	always_comb begin
		clr_hi = (upper_clear_sel == `TMR_CLR_MATCH_A && m_ua)
			|| (upper_clear_sel == `TMR_CLR_MATCH_B && m_ub)
			|| (upper_clear_sel == `TMR_CLR_CAPTURE && cap);
		clr_lo = (lower_clear_sel == `TMR_CLR_MATCH_A && m_la)
			|| (lower_clear_sel == `TMR_CLR_MATCH_B && m_lb)
			|| (lower_clear_sel == `TMR_CLR_CAPTURE && cap);
		if (cascade16) begin
			clr_lo = clr_hi;
		end
	end

	// ************************************************************
	// counter and constant registers
	// ************************************************************

	always_comb begin
		wr_cnt_hi = cpu_wr_t3 && cpu_sel == `TMR_SEL_CNT_HI;
		wr_cnt_lo = cpu_wr_t3 && cpu_sel == `TMR_SEL_CNT_LO;
		wr_cb_hi  = cpu_wr_t3 && cpu_sel == `TMR_SEL_CB_HI;
		wr_cb_lo  = cpu_wr_t3 && cpu_sel == `TMR_SEL_CB_LO;
		inc_hi    = cascade16 ? 1'b0 : tick_hi;
		inc_lo    = tick_lo;
		sum16     = {1'b0, s.cnt_hi, s.cnt_lo} + `TMR_STEP16;
		// an increment in T2 is applied, the T3 write then lands
		base16    = inc_lo ? sum16[15:0] : {s.cnt_hi, s.cnt_lo};
		ovf_lo    = inc_lo && s.cnt_lo == `TMR_BYTE_MAX && !clr_lo && !wr_cnt_lo;
		ovf_hi    = cascade16 ? (inc_lo && sum16[16] && !clr_hi && !wr_cnt_hi)
			: (inc_hi && s.cnt_hi == `TMR_BYTE_MAX && !clr_hi && !wr_cnt_hi);
	end

	always_comb begin
		next_s = s;
		// synchronisers; the first stage feeds only the second
		next_s.cap_s1   = capture_pin;
		next_s.cap_s2   = s.cap_s1;
		next_s.cap_prev = s.cap_s2;
		next_s.clk_s1   = ext_clock_pin;
		next_s.clk_s2   = s.clk_s1;
		next_s.trg_s1   = ext_conv_trigger_pin;
		next_s.trg_s2   = s.trg_s1;
		next_s.presc    = s.presc + `TMR_STEP;
		next_s.eq_prev  = {eq_lb, eq_la, eq_ub, eq_ua};

		// counters: clear, then write, then increment
		if (cascade16) begin
			// the byte not written still takes its increment
			next_s.cnt_hi = wr_cnt_hi ? cpu_wdata : base16[15:8];
			next_s.cnt_lo = wr_cnt_lo ? cpu_wdata : base16[7:0];
		end else begin
			if (wr_cnt_hi) begin
				next_s.cnt_hi = cpu_wdata;
			end else if (inc_hi) begin
				next_s.cnt_hi = s.cnt_hi + `TMR_STEP;
			end
			if (wr_cnt_lo) begin
				next_s.cnt_lo = cpu_wdata;
			end else if (inc_lo) begin
				next_s.cnt_lo = s.cnt_lo + `TMR_STEP;
			end
		end
		// a capture clear drops the increment too
		if (clr_hi && cascade16) begin
			next_s.cnt_hi = `TMR_BYTE_ZERO;
		end else if (clr_hi) begin
			next_s.cnt_hi = `TMR_BYTE_ZERO;
		end
		if (clr_lo) begin
			next_s.cnt_lo = `TMR_BYTE_ZERO;
		end

		// constant a registers take the write
		if (cpu_wr_t3 && cpu_sel == `TMR_SEL_CA_HI) begin
			next_s.ca_hi = cpu_wdata;
		end
		if (cpu_wr_t3 && cpu_sel == `TMR_SEL_CA_LO) begin
			next_s.ca_lo = cpu_wdata;
		end
		// capture takes the pre-clear count and beats the write
		if (cap) begin
			next_s.cb_lo = s.cnt_lo;
			if (cascade16) begin
				next_s.cb_hi = s.cnt_hi;
			end else if (wr_cb_hi) begin
				next_s.cb_hi = cpu_wdata;
			end
		end else begin
			if (wr_cb_hi) begin
				next_s.cb_hi = cpu_wdata;
			end
			if (wr_cb_lo) begin
				next_s.cb_lo = cpu_wdata;
			end
		end

		// flags: a set in the clearing cycle wins
		set_flags = '0;
		set_flags[`TMR_FLG_UA] = m_ua;
		set_flags[`TMR_FLG_UB] = m_ub || (cap && cascade16);
		set_flags[`TMR_FLG_UO] = ovf_hi;
		set_flags[`TMR_FLG_LA] = m_la;
		set_flags[`TMR_FLG_LB] = m_lb || cap;
		set_flags[`TMR_FLG_LO] = ovf_lo;
		next_s.flags = (s.flags & ~flag_clear) | set_flags;

		// converter start only from the upper match a flag set
		next_s.conv_req = m_ua && conv_trigger_enable;
		// external trigger pin is masked while enabled
		next_s.conv_ext = s.trg_s2 && !conv_trigger_enable;
		// both lower match sources share one request
		next_s.match_irq = (next_s.flags[`TMR_FLG_LA] && lower_match_a_ie)
			|| (next_s.flags[`TMR_FLG_LB] && lower_match_b_ie);
		// either overflow drives the shared request
		next_s.ovf_irq = (next_s.flags[`TMR_FLG_UO] && upper_ovf_ie)
			|| (next_s.flags[`TMR_FLG_LO] && lower_ovf_ie);

		// read data comes from the old state, so a capture is not seen
		if (cpu_rd_t3) begin
			if (cpu_sel == `TMR_SEL_CNT_HI) begin
				next_s.rdata = s.cnt_hi;
			end else if (cpu_sel == `TMR_SEL_CNT_LO) begin
				next_s.rdata = s.cnt_lo;
			end else if (cpu_sel == `TMR_SEL_CA_HI) begin
				next_s.rdata = s.ca_hi;
			end else if (cpu_sel == `TMR_SEL_CA_LO) begin
				next_s.rdata = s.ca_lo;
			end else if (cpu_sel == `TMR_SEL_CB_HI) begin
				next_s.rdata = s.cb_hi;
			end else if (cpu_sel == `TMR_SEL_CB_LO) begin
				next_s.rdata = s.cb_lo;
			end else begin
				next_s.rdata = `TMR_BYTE_ZERO;
			end
		end
	end

	// constants reset to all ones so no match fires at start
	always_ff @(posedge clock) begin
		if (rst) begin
			s       <= '0;
			s.ca_hi <= `TMR_BYTE_MAX;
			s.ca_lo <= `TMR_BYTE_MAX;
			s.cb_hi <= `TMR_BYTE_MAX;
			s.cb_lo <= `TMR_BYTE_MAX;
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************

	tmr_outctl u_out_hi (
		.clock   (clock),
		.rst     (rst),
		.match_a (m_ua),
		.match_b (m_ub),
		.sel_a   (upper_out_sel_a),
		.sel_b   (upper_out_sel_b),
		.pin     (upper_timer_out)
	);

	tmr_outctl u_out_lo (
		.clock   (clock),
		.rst     (rst),
		.match_a (m_la),
		.match_b (m_lb),
		.sel_a   (lower_out_sel_a),
		.sel_b   (lower_out_sel_b),
		.pin     (lower_timer_out)
	);

	assign cpu_rdata        = s.rdata;
	assign flags            = s.flags;
	assign conv_start_req   = s.conv_req;
	assign conv_ext_trigger = s.conv_ext;
	assign lower_match_irq  = s.match_irq;
	assign shared_ovf_irq   = s.ovf_irq;

	// ************************************************************
	// assertions
	// ************************************************************

	property p_conv_req;
		@(posedge clock) disable iff (rst)
		conv_start_req |-> $past(conv_trigger_enable) && s.flags[`TMR_FLG_UA];
	endproperty
	a_conv_req: assert property (p_conv_req) else $error("stray converter start");

	property p_ext_block;
		@(posedge clock) disable iff (rst)
		$past(conv_trigger_enable) |-> !conv_ext_trigger;
	endproperty
	a_ext_block: assert property (p_ext_block) else $error("trigger pin not masked");

	property p_clear_a;
		@(posedge clock) disable iff (rst)
		upper_clear_sel == `TMR_CLR_MATCH_A && m_ua |=> s.cnt_hi == `TMR_BYTE_ZERO;
	endproperty
	a_clear_a: assert property (p_clear_a) else $error("match a did not clear");

	property p_wr_clear;
		@(posedge clock) disable iff (rst)
		wr_cnt_lo && clr_lo |=> s.cnt_lo == `TMR_BYTE_ZERO;
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("write beat the clear");

	property p_wr_inc;
		@(posedge clock) disable iff (rst)
		!cascade16 && wr_cnt_lo && inc_lo && !clr_lo |=> s.cnt_lo == $past(cpu_wdata);
	endproperty
	a_wr_inc: assert property (p_wr_inc) else $error("increment beat the write");

	property p_rd_cap;
		@(posedge clock) disable iff (rst)
		cpu_rd_t3 && cpu_sel == `TMR_SEL_CB_LO && cap |=> cpu_rdata == $past(s.cb_lo);
	endproperty
	a_rd_cap: assert property (p_rd_cap) else $error("read saw the capture");

	property p_cap_clr;
		@(posedge clock) disable iff (rst)
		!cascade16 && cap && lower_clear_sel == `TMR_CLR_CAPTURE
			|=> s.cnt_lo == `TMR_BYTE_ZERO && s.cb_lo == $past(s.cnt_lo);
	endproperty
	a_cap_clr: assert property (p_cap_clr) else $error("capture clear wrong");

	property p_cap_wr;
		@(posedge clock) disable iff (rst)
		cap && wr_cb_lo |=> s.cb_lo == $past(s.cnt_lo);
	endproperty
	a_cap_wr: assert property (p_cap_wr) else $error("write beat the capture");

	property p_byte_wr;
		@(posedge clock) disable iff (rst)
		cascade16 && wr_cnt_hi && inc_lo && !clr_hi
			|=> s.cnt_hi == $past(cpu_wdata) && s.cnt_lo == $past(s.cnt_lo) + `TMR_STEP;
	endproperty
	a_byte_wr: assert property (p_byte_wr) else $error("byte write mishandled");

	property p_t2_inc;
		@(posedge clock) disable iff (rst)
		cascade16 && cpu_wr_t2 && !cpu_wr_t3 && inc_lo && !clr_hi
			|=> {s.cnt_hi, s.cnt_lo} == $past(sum16[15:0]);
	endproperty
	a_t2_inc: assert property (p_t2_inc) else $error("T2 increment lost");

	property p_ovf_irq;
		@(posedge clock) disable iff (rst)
		ovf_hi && upper_ovf_ie |=> shared_ovf_irq;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("shared overflow missing");
endmodule : tmr_pair

/* File: logic/tmr_defines.svh */
// named constants of the cascadable 8-bit timer pair
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
// clock select codes
`define TMR_CS_HALT      3'h0
`define TMR_CS_TAP1      3'h1
`define TMR_CS_TAP2      3'h2
`define TMR_CS_TAP3      3'h3
`define TMR_CS_CASCADE   3'h4
`define TMR_CS_EXT_RISE  3'h5
`define TMR_CS_EXT_FALL  3'h6
`define TMR_CS_EXT_BOTH  3'h7
// clear select codes
`define TMR_CLR_MATCH_A  2'h1
`define TMR_CLR_MATCH_B  2'h2
`define TMR_CLR_CAPTURE  2'h3
// capture edge select codes
`define TMR_EDGE_RISE    2'h1
`define TMR_EDGE_FALL    2'h2
// output select codes
`define TMR_OUT_LOW      2'h1
`define TMR_OUT_HIGH     2'h2
`define TMR_OUT_TOGGLE   2'h3
// cpu register select codes
`define TMR_SEL_CNT_HI   3'h0
`define TMR_SEL_CNT_LO   3'h1
`define TMR_SEL_CA_HI    3'h2
`define TMR_SEL_CA_LO    3'h3
`define TMR_SEL_CB_HI    3'h4
`define TMR_SEL_CB_LO    3'h5
// flag bit positions
`define TMR_FLG_UA       0
`define TMR_FLG_UB       1
`define TMR_FLG_UO       2
`define TMR_FLG_LA       3
`define TMR_FLG_LB       4
`define TMR_FLG_LO       5
// prescaler tap bit positions
`define TMR_TAP1_BIT     1
`define TMR_TAP2_BIT     3
`define TMR_TAP3_BIT     5
// byte values and the 16-bit step
`define TMR_BYTE_ZERO    8'h00
`define TMR_BYTE_MAX     8'hFF
`define TMR_STEP         8'h01
`define TMR_STEP16       17'h00001
`endif

/* File: logic/tmr_pkg.sv */
// types shared by the timer pair modules
package tmr_pkg;
	// output action, one-hot
	typedef enum logic [3:0] {
		TMR_ACT_NONE   = 4'b0001,
		TMR_ACT_LOW    = 4'b0010,
		TMR_ACT_HIGH   = 4'b0100,
		TMR_ACT_TOGGLE = 4'b1000
	} tmr_act_e;
	// clock edge detector state
	typedef struct packed {
		logic [2:0] sel_prev;
		logic       lvl_prev;
	} tmr_tick_s;
	// output pin state
	typedef struct packed {
		logic pin;
	} tmr_out_s;
	// core state of the pair
	typedef struct packed {
		logic [7:0] cnt_hi;
		logic [7:0] cnt_lo;
		logic [7:0] ca_hi;
		logic [7:0] ca_lo;
		logic [7:0] cb_hi;
		logic [7:0] cb_lo;
		logic [5:0] flags;
		logic [3:0] eq_prev;
		logic       cap_s1;
		logic       cap_s2;
		logic       cap_prev;
		logic       clk_s1;
		logic       clk_s2;
		logic       trg_s1;
		logic       trg_s2;
		logic [7:0] presc;
		logic [7:0] rdata;
		logic       conv_req;
		logic       conv_ext;
		logic       match_irq;
		logic       ovf_irq;
	} tmr_core_s;
endpackage : tmr_pkg

/* File: logic/tmr_tick.sv */
// counter clock generation from the selected source
`timescale 1ns/100ps
`include "tmr_defines.svh"
module tmr_tick import tmr_pkg::*; (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [2:0] clock_sel,
	input  wire logic [2:0] taps,
	input  wire logic       ext_level,
	input  wire logic       cascade_pulse,
	output logic            tick
);
	tmr_tick_s s;
	tmr_tick_s next_s;
	logic      lvl;
	logic      sel_changed;

	// level of the source; a halted source reads as high
	always_comb begin
		next_s      = s;
		lvl         = 1'b1;
		sel_changed = (clock_sel != s.sel_prev);
		case (clock_sel)
			`TMR_CS_TAP1:     lvl = taps[0];
			`TMR_CS_TAP2:     lvl = taps[1];
			`TMR_CS_TAP3:     lvl = taps[2];
			`TMR_CS_EXT_RISE: lvl = ext_level;
			`TMR_CS_EXT_FALL: lvl = ~ext_level;
			`TMR_CS_EXT_BOTH: lvl = ext_level;
			default:          lvl = 1'b1;
		endcase
		// rising edge of the level gives a count
		// internal and external sources share this path, so a switch may count
		// old low to new high looks like an edge
		tick = lvl & ~s.lvl_prev;
		// old low to new low is still taken as an edge
		// old high never adds a count on a switch
		if (sel_changed && !s.lvl_prev) begin
			tick = 1'b1;
		end
		if (clock_sel == `TMR_CS_EXT_BOTH && !sel_changed && s.lvl_prev && !lvl) begin
			tick = 1'b1;
		end
		if (clock_sel == `TMR_CS_CASCADE) begin
			tick = cascade_pulse;
		end
		next_s.lvl_prev = lvl;
		next_s.sel_prev = clock_sel;
	end

	// lvl_prev resets high so reset release never counts
	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '{sel_prev: `TMR_CS_HALT, lvl_prev: 1'b1};
		end else begin
			s <= next_s;
		end
	end
endmodule : tmr_tick

/* File: logic/tmr_outctl.sv */
// timer output pin driven by compare matches a and b
`timescale 1ns/100ps
`include "tmr_defines.svh"
module tmr_outctl import tmr_pkg::*; (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       match_a,
	input  wire logic       match_b,
	input  wire logic [1:0] sel_a,
	input  wire logic [1:0] sel_b,
	output logic            pin
);
	tmr_out_s s;
	tmr_out_s next_s;
	tmr_act_e act_a;
	tmr_act_e act_b;
	tmr_act_e act;

	function automatic tmr_act_e decode(input logic hit, input logic [1:0] code);
		tmr_act_e r;
		r = TMR_ACT_NONE;
		if (hit) begin
			case (code)
				`TMR_OUT_LOW:    r = TMR_ACT_LOW;
				`TMR_OUT_HIGH:   r = TMR_ACT_HIGH;
				`TMR_OUT_TOGGLE: r = TMR_ACT_TOGGLE;
				default:         r = TMR_ACT_NONE;
			endcase
		end
		return r;
	endfunction : decode

	// a high on a, low on b gives a pulse with no software
	// coinciding matches: toggle, then high, then low, then none
	always_comb begin
		next_s = s;
		act_a  = decode(match_a, sel_a);
		act_b  = decode(match_b, sel_b);
		act    = (act_a > act_b) ? act_a : act_b;
		case (act)
			TMR_ACT_LOW:    next_s.pin = 1'b0;
			TMR_ACT_HIGH:   next_s.pin = 1'b1;
			TMR_ACT_TOGGLE: next_s.pin = ~s.pin;
			default:        next_s.pin = s.pin;
		endcase
		pin = s.pin;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	property p_out_prio;
		@(posedge clock) disable iff (rst)
		match_a && match_b && sel_a == `TMR_OUT_TOGGLE |=> pin != $past(pin);
	endproperty
	a_out_prio: assert property (p_out_prio) else $error("toggle lost to other action");

	property p_out_pulse;
		@(posedge clock) disable iff (rst)
		match_a && !match_b && sel_a == `TMR_OUT_HIGH ##1 match_b && !match_a
			&& sel_b == `TMR_OUT_LOW |=> !pin;
	endproperty
	a_out_pulse: assert property (p_out_pulse) else $error("pulse not ended by b");
endmodule : tmr_outctl

/* File: tb/tmr_adc_model.sv */
// converter stand-in that counts start requests from the timer pair
`timescale 1ns/100ps
module tmr_adc_model (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic conv_start_req,
	input  wire logic conv_trigger_gate,
	output int        n_starts
);
	// a request starts a conversion only while the gate is open
	always_ff @(posedge clock) begin
		if (rst)
			n_starts <= 0;
		else if (conv_start_req && conv_trigger_gate)
			n_starts <= n_starts + 1;
	end
endmodule : tmr_adc_model

/* File: tb/tb.sv */
// self-checking bench of the cascadable timer pair
`timescale 1ns/100ps
module tb;
	logic       clock, rst, capture_enable, cpu_wr_t2, cpu_wr_t3, cpu_rd_t3;
	logic       conv_trigger_enable, ext_clock_pin, capture_pin, ext_conv_trigger_pin;
	logic       lower_match_a_ie, lower_match_b_ie, upper_ovf_ie, lower_ovf_ie;
	logic [2:0] upper_clock_sel, lower_clock_sel, cpu_sel;
	logic [1:0] upper_clear_sel, lower_clear_sel, capture_edge_sel;
	logic [1:0] upper_out_sel_a, upper_out_sel_b, lower_out_sel_a, lower_out_sel_b;
	logic [5:0] flag_clear, flags;
	logic [7:0] cpu_wdata, cpu_rdata;
	logic       upper_timer_out, lower_timer_out, conv_start_req, conv_ext_trigger;
	logic       lower_match_irq, shared_ovf_irq;
	int         n_starts, n_errors, total_checks;

	tmr_pair dut (.clock, .rst, .upper_clock_sel, .lower_clock_sel, .upper_clear_sel,
		.lower_clear_sel, .upper_out_sel_a, .upper_out_sel_b, .lower_out_sel_a,
		.lower_out_sel_b, .capture_enable, .capture_edge_sel, .conv_trigger_enable,
		.lower_match_a_ie, .lower_match_b_ie, .upper_ovf_ie, .lower_ovf_ie, .flag_clear,
		.ext_clock_pin, .capture_pin, .ext_conv_trigger_pin, .cpu_sel, .cpu_wr_t2,
		.cpu_wr_t3, .cpu_rd_t3, .cpu_wdata, .cpu_rdata, .flags, .upper_timer_out,
		.lower_timer_out, .conv_start_req, .conv_ext_trigger, .lower_match_irq,
		.shared_ovf_irq);
	tmr_adc_model adc (.clock, .rst, .conv_start_req, .conv_trigger_gate(1'b1),
		.n_starts);

	// ************************************************************
	// bench tasks
	// ************************************************************
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// T2 then T3, each strobe held for exactly one rising edge
	task automatic cpu_wr(input logic [2:0] sel, input logic [7:0] d);
		@(negedge clock);
		cpu_sel = sel;
		cpu_wdata = d;
		cpu_wr_t2 = 1'b1;
		@(negedge clock);
		cpu_wr_t2 = 1'b0;
		cpu_wr_t3 = 1'b1;
		@(negedge clock);
		cpu_wr_t3 = 1'b0;
	endtask : cpu_wr

	task automatic cpu_rd(input logic [2:0] sel, input logic [7:0] exp);
		@(negedge clock);
		cpu_sel = sel;
		cpu_rd_t3 = 1'b1;
		@(negedge clock);
		cpu_rd_t3 = 1'b0;
		check(cpu_rdata, exp);
	endtask : cpu_rd

	task automatic clr_flags(input logic [5:0] m);
		@(negedge clock);
		flag_clear = m;
		@(negedge clock);
		flag_clear = 6'h00;
	endtask : clr_flags

	// bounded wait; a hang ends the run as a mismatch
	task automatic wait_flag(input int idx);
		int n;
		n = 0;
		while (flags[idx] !== 1'b1 && n < 4000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 4000) begin
			n_errors++;
			$display("Error at %0t: flag wait timed out", $time);
			finish_test();
		end
	endtask : wait_flag

	// ************************************************************
	// clock, reset and scenarios
	// ************************************************************
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		{capture_enable, cpu_wr_t2, cpu_wr_t3, cpu_rd_t3, conv_trigger_enable} = '0;
		{ext_clock_pin, capture_pin, ext_conv_trigger_pin} = '0;
		{lower_match_a_ie, lower_match_b_ie, upper_ovf_ie, lower_ovf_ie} = '0;
		{upper_clock_sel, lower_clock_sel, cpu_sel} = '0;
		{upper_clear_sel, lower_clear_sel, capture_edge_sel} = '0;
		{upper_out_sel_a, upper_out_sel_b, lower_out_sel_a, lower_out_sel_b} = '0;
		{flag_clear, cpu_wdata} = '0;
		n_errors = 0;
		total_checks = 0;
		rst = 1'b1;
		repeat (8) @(negedge clock);
		rst = 1'b0;
		// reset state and an unmapped select
		cpu_rd(3'h4, 8'hFF);
		cpu_rd(3'h0, 8'h00);
		cpu_rd(3'h6, 8'h00);
		// pulse output: period from match a, width from match b
		cpu_wr(3'h2, 8'h03);
		cpu_wr(3'h4, 8'h01);
		upper_clear_sel = 2'h1;
		upper_out_sel_a = 2'h2;
		upper_out_sel_b = 2'h1;
		conv_trigger_enable = 1'b1;
		ext_conv_trigger_pin = 1'b1;
		upper_clock_sel = 3'h1;
		wait_flag(0);
		@(negedge clock);
		check({7'h00, upper_timer_out}, 8'h01);
		cpu_rd(3'h0, 8'h00);
		check(n_starts[7:0], 8'h01);
		check({7'h00, conv_ext_trigger}, 8'h00);
		clr_flags(6'h02);
		wait_flag(1);
		@(negedge clock);
		check({7'h00, upper_timer_out}, 8'h00);
		upper_clock_sel = 3'h0;
		conv_trigger_enable = 1'b0;
		repeat (6) @(negedge clock);
		check({7'h00, conv_ext_trigger}, 8'h01);
		// lower channel wraps, then a and b match together
		cpu_wr(3'h3, 8'h02);
		cpu_wr(3'h5, 8'h02);
		cpu_wr(3'h1, 8'hFE);
		clr_flags(6'h3F);
		{lower_ovf_ie, lower_match_a_ie} = 2'b11;
		{lower_out_sel_a, lower_out_sel_b} = 4'hD;
		lower_clock_sel = 3'h1;
		wait_flag(5);
		repeat (2) @(negedge clock);
		check({7'h00, shared_ovf_irq}, 8'h01);
		wait_flag(3);
		repeat (2) @(negedge clock);
		check({7'h00, lower_match_irq}, 8'h01);
		check({7'h00, lower_timer_out}, 8'h01);
		lower_clock_sel = 3'h5;
		lower_ovf_ie = 1'b0;
		clr_flags(6'h3F);
		@(negedge clock);
		check({7'h00, shared_ovf_irq}, 8'h00);
		// external edge lands in T3 of a counter write
		ext_clock_pin = 1'b1;
		cpu_wr(3'h1, 8'h40);
		cpu_rd(3'h1, 8'h40);
		// capture edge, external edge and a T3 capture register write meet
		ext_clock_pin = 1'b0;
		{capture_enable, capture_edge_sel, lower_clear_sel} = 5'h1F;
		repeat (4) @(negedge clock);
		{ext_clock_pin, capture_pin} = 2'h3;
		cpu_wr(3'h5, 8'h77);
		cpu_rd(3'h5, 8'h40);
		cpu_rd(3'h1, 8'h00);
		// falling capture edge lands in T3 of a read
		capture_pin = 1'b0;
		@(negedge clock);
		cpu_rd(3'h5, 8'h40);
		cpu_rd(3'h5, 8'h00);
		// capture clear lands in T3 of a counter write
		capture_pin = 1'b1;
		cpu_wr(3'h1, 8'h66);
		cpu_rd(3'h1, 8'h00);
		// low external level switched to halted counts once
		{capture_pin, ext_clock_pin, capture_enable, capture_edge_sel, lower_clear_sel} = '0;
		repeat (4) @(negedge clock);
		lower_clock_sel = 3'h0;
		cpu_rd(3'h1, 8'h01);
		// 16-bit mode on the external clock
		upper_clock_sel = 3'h4;
		lower_clock_sel = 3'h5;
		cpu_wr(3'h0, 8'h12);
		cpu_wr(3'h1, 8'hFF);
		clr_flags(6'h3F);
		// increment in T2 of a low byte write still carries into the high byte
		ext_clock_pin = 1'b1;
		@(negedge clock);
		cpu_wr(3'h1, 8'h80);
		wait_flag(5);
		cpu_rd(3'h0, 8'h13);
		check({7'h00, flags[2]}, 8'h00);
		// increment in T3 of a high byte write steps only the low byte
		ext_clock_pin = 1'b0;
		repeat (4) @(negedge clock);
		ext_clock_pin = 1'b1;
		cpu_wr(3'h0, 8'h55);
		cpu_rd(3'h0, 8'h55);
		cpu_rd(3'h1, 8'h81);
		finish_test();
	end
endmodule : tb
